// file: design/ch2_shared_data_bit3_pin_mux.sv
// Purpose: role selection and timing of the channel 2 shared data bit 3 pin
// Assumes: pclk 40 MHz; add bus clock is its own domain; other pins are asynchronous
// Notes:   byte clock and drop port clock are made here by dividing pclk
//
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/1ps

module ch2_shared_data_bit3_pin_mux #(
  parameter logic [pin_mux_pkg::DIV_W-1:0] PKT_HALF  = pin_mux_pkg::DIV_W'(pin_mux_pkg::PKT_HALF_CYC),
  parameter logic [pin_mux_pkg::DIV_W-1:0] PORT_HALF = pin_mux_pkg::DIV_W'(pin_mux_pkg::PORT_HALF_CYC)
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire pin_mux_pkg::apb_req_s apb_req,
  output pin_mux_pkg::apb_rsp_s      apb_rsp,
  input  wire logic                  add_bus_ch2_clock,
  input  wire logic                  pin_in,
  output pin_mux_pkg::pin_drv_s      pin_drv,
  input  wire logic                  port_clock_in,
  output pin_mux_pkg::pin_drv_s      port_clock_drv,
  output logic                       pkt_ctrl_ch2_byte_clock,
  input  wire logic                  drop_neg_data,
  output logic                       drop_req,
  output pin_mux_pkg::cap_s          cap
);
  import pin_mux_pkg::*;

  typedef struct packed {
    logic                 add_en;
    logic [1:0]           mode;
    logic                 port_drop;
    apb_rsp_s             rsp;
    role_e                role;
    logic                 tog_s1;
    logic                 tog_s2;
    logic                 tog_s3;
    logic                 pin_s1;
    logic                 pin_s2;
    logic                 lclk_s1;
    logic                 lclk_s2;
    logic                 lclk_s3;
    logic [DIV_W-1:0]     pkt_div;
    logic                 pkt_clk;
    logic [SYNC_LAT-1:0]  pkt_rise_d;
    logic [DIV_W-1:0]     port_div;
    logic                 port_clk;
    logic                 port_clk_oe_n;
    pin_drv_s             drv;
    logic                 last_add;
    logic                 last_pkt;
    logic                 last_port;
    logic [HIST_W-1:0]    hist_add;
    logic [HIST_W-1:0]    hist_pkt;
    logic [HIST_W-1:0]    hist_port;
    logic [CNT_W-1:0]     count;
    cap_s                 cap;
    logic                 drop_req;
  } state_s;

  state_s r;
  state_s next_r;

  logic link_toggle;
  logic link_bit;

  // ==========================================================
  // add bus domain
  add_bus_capture u_add_bus_capture (
    .add_bus_ch2_clock (add_bus_ch2_clock),
    .presetn           (presetn),
    .add_bus_ch2_bit3  (pin_in),
    .cap_toggle        (link_toggle),
    .cap_bit           (link_bit)
  );

  // ==========================================================
  // next state
  always_comb begin
    logic             acc;
    logic             wr_count;
    logic             event_seen;
    logic             event_bit;
    logic [DIV_W-1:0] div_next;
    next_r     = r;
    acc        = 1'b0;
    wr_count   = 1'b0;
    event_seen = 1'b0;
    event_bit  = 1'b0;
    div_next   = '0;

    // ---- apb slave: one wait state, then the answer
    next_r.rsp.pready = 1'b0;
    if (apb_req.psel && apb_req.penable && !r.rsp.pready) begin
      next_r.rsp.pready  = 1'b1;
      next_r.rsp.pslverr = 1'b0;
      next_r.rsp.prdata  = '0;
      unique case (apb_req.paddr)
        CTRL_OFS: begin
          next_r.rsp.prdata[CTRL_ADD_EN_BIT]                = r.add_en;
          next_r.rsp.prdata[CTRL_MODE_LSB +: 2]             = r.mode;
          next_r.rsp.prdata[CTRL_PORT_DROP]                 = r.port_drop;
        end
        STATUS_OFS: begin
          next_r.rsp.prdata[STAT_ROLE_LSB +: $bits(role_e)] = r.role;
          next_r.rsp.prdata[STAT_ADD_BIT]                   = r.last_add;
          next_r.rsp.prdata[STAT_PKT_BIT]                   = r.last_pkt;
          next_r.rsp.prdata[STAT_PORT_BIT]                  = r.last_port;
        end
        HIST_OFS: begin
          next_r.rsp.prdata[HIST_ADD_LSB +: HIST_W]         = r.hist_add;
          next_r.rsp.prdata[HIST_PKT_LSB +: HIST_W]         = r.hist_pkt;
          next_r.rsp.prdata[HIST_PORT_LSB +: HIST_W]        = r.hist_port;
        end
        COUNT_OFS: begin
          next_r.rsp.prdata[CNT_W-1:0]                      = r.count;
        end
        default: begin
          next_r.rsp.pslverr = 1'b1;
        end
      endcase
    end
    // write lands on the edge where pready is seen high
    acc = apb_req.psel && apb_req.penable && r.rsp.pready;
    if (acc && apb_req.pwrite) begin
      if (apb_req.paddr == CTRL_OFS) begin
        next_r.add_en    = apb_req.pwdata[CTRL_ADD_EN_BIT];
        next_r.mode      = apb_req.pwdata[CTRL_MODE_LSB +: 2];
        next_r.port_drop = apb_req.pwdata[CTRL_PORT_DROP];
      end
      wr_count = (apb_req.paddr == COUNT_OFS);
    end

    // ---- role selection
    if (r.add_en) begin
      next_r.role = ROLE_ADD_BUS;
    end else if (r.mode == MODE_PKT) begin
      next_r.role = ROLE_PKT_IN;
    end else if (r.mode == MODE_MAPPER) begin
      next_r.role = r.port_drop ? ROLE_PORT_DROP : ROLE_PORT_ADD;
    end else begin
      next_r.role = ROLE_IDLE;
    end

    // ---- synchronisers
    next_r.tog_s1  = link_toggle;
    next_r.tog_s2  = r.tog_s1;
    next_r.tog_s3  = r.tog_s2;
    next_r.pin_s1  = pin_in;
    next_r.pin_s2  = r.pin_s1;
    next_r.lclk_s1 = port_clock_in;
    next_r.lclk_s2 = r.lclk_s1;
    next_r.lclk_s3 = r.lclk_s2;

    // ---- add bus: bit held stable in its domain until the next falling edge
    if (r.tog_s2 != r.tog_s3) begin
      next_r.last_add = link_bit;
      next_r.hist_add = {r.hist_add[HIST_W-2:0], link_bit};
      if (r.role == ROLE_ADD_BUS) begin
        event_seen = 1'b1;
        event_bit  = link_bit;
      end
    end

    // ---- byte clock for the packet input bus
    next_r.pkt_rise_d = {r.pkt_rise_d[SYNC_LAT-2:0], 1'b0};
    if (r.role == ROLE_PKT_IN) begin
      div_next = r.pkt_div + DIV_W'(1);
      if (div_next >= PKT_HALF) begin
        next_r.pkt_div = '0;
        next_r.pkt_clk = ~r.pkt_clk;
        next_r.pkt_rise_d[0] = ~r.pkt_clk;
      end else begin
        next_r.pkt_div = div_next;
      end
    end else begin
      next_r.pkt_div = '0;
      next_r.pkt_clk = 1'b0;
    end
    // pin value from the rising edge, seen after the synchroniser delay
    if (r.pkt_rise_d[SYNC_LAT-1] && r.role == ROLE_PKT_IN) begin
      next_r.last_pkt = r.pin_s2;
      next_r.hist_pkt = {r.hist_pkt[HIST_W-2:0], r.pin_s2};
      event_seen      = 1'b1;
      event_bit       = r.pin_s2;
    end

    // ---- low-rate port, add direction: external clock and data
    if (r.role == ROLE_PORT_ADD && r.lclk_s2 && !r.lclk_s3) begin
      next_r.last_port = r.pin_s2;
      next_r.hist_port = {r.hist_port[HIST_W-2:0], r.pin_s2};
      event_seen       = 1'b1;
      event_bit        = r.pin_s2;
    end

    // ---- low-rate port, drop direction: clock made here
    next_r.drop_req = 1'b0;
    if (r.role == ROLE_PORT_DROP) begin
      next_r.port_clk_oe_n = 1'b0;
      div_next = r.port_div + DIV_W'(1);
      if (div_next >= PORT_HALF) begin
        next_r.port_div = '0;
        next_r.port_clk = ~r.port_clk;
        if (r.port_clk) begin
          next_r.drv.o     = drop_neg_data;
          next_r.last_port = drop_neg_data;
          next_r.hist_port = {r.hist_port[HIST_W-2:0], drop_neg_data};
          next_r.drop_req  = 1'b1;
          event_seen       = 1'b1;
          event_bit        = drop_neg_data;
        end
      end else begin
        next_r.port_div = div_next;
      end
    end else begin
      next_r.port_clk_oe_n = 1'b1;
      next_r.port_div      = '0;
      next_r.port_clk      = 1'b0;
      next_r.drv.o         = 1'b0;
    end
    // driver only while the role is drop; same cycle as the port clock driver
    next_r.drv.oe_n = (r.role != ROLE_PORT_DROP);

    // ---- capture stream and counter; a capture in the same cycle as a clearing write leaves the count at 1
    next_r.cap.valid = event_seen;
    next_r.cap.data  = event_bit;
    next_r.cap.role  = r.role;
    if (wr_count) begin
      next_r.count = event_seen ? CNT_W'(1) : '0;
    end else if (event_seen) begin
      next_r.count = r.count + CNT_W'(1);
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r           <= '0;
      r.add_en    <= CTRL_ADD_EN_RST;
      r.mode      <= CTRL_MODE_RST;
      r.port_drop <= CTRL_DROP_RST;
      r.role      <= ROLE_IDLE;
      r.drv.oe_n  <= 1'b1;
      r.port_clk_oe_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================
  // outputs
  assign apb_rsp                 = r.rsp;
  assign pin_drv                 = r.drv;
  assign port_clock_drv.o        = r.port_clk;
  assign port_clock_drv.oe_n     = r.port_clk_oe_n;
  assign pkt_ctrl_ch2_byte_clock = r.pkt_clk;
  assign drop_req                = r.drop_req;
  assign cap                     = r.cap;

endmodule

// file: design/pin_mux_pkg.sv
// Purpose: shared constants and carriers for the channel 2 shared data bit 3 pin mux
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   all offsets are byte addresses
package pin_mux_pkg;

  // ==========================================================
  // bus layout
  localparam int unsigned APB_AW = 12;
  localparam int unsigned APB_DW = 32;

  // ==========================================================
  // register offsets
  localparam logic [APB_AW-1:0] CTRL_OFS   = 12'h000;
  localparam logic [APB_AW-1:0] STATUS_OFS = 12'h004;
  localparam logic [APB_AW-1:0] HIST_OFS   = 12'h008;
  localparam logic [APB_AW-1:0] COUNT_OFS  = 12'h00C;

  // ==========================================================
  // control fields
  localparam int unsigned CTRL_ADD_EN_BIT  = 0;
  localparam int unsigned CTRL_MODE_LSB    = 1;
  localparam int unsigned CTRL_PORT_DROP   = 3;
  localparam logic [1:0]  MODE_PKT         = 2'h0;
  localparam logic [1:0]  MODE_MAPPER      = 2'h1;
  localparam logic        CTRL_ADD_EN_RST  = 1'h0;
  localparam logic [1:0]  CTRL_MODE_RST    = 2'h3;
  localparam logic        CTRL_DROP_RST    = 1'h0;

  // ==========================================================
  // status fields
  localparam int unsigned STAT_ROLE_LSB    = 0;
  localparam int unsigned STAT_ADD_BIT     = 4;
  localparam int unsigned STAT_PKT_BIT     = 5;
  localparam int unsigned STAT_PORT_BIT    = 6;
  localparam int unsigned HIST_ADD_LSB     = 0;
  localparam int unsigned HIST_PKT_LSB     = 8;
  localparam int unsigned HIST_PORT_LSB    = 16;
  localparam int unsigned HIST_W           = 8;
  localparam int unsigned CNT_W            = 16;

  // ==========================================================
  // timing: half periods of the clocks this block makes, in pclk cycles
  localparam int unsigned DIV_W            = 8;
  localparam int unsigned PKT_HALF_CYC     = 4;
  localparam int unsigned PORT_HALF_CYC    = 4;
  // pin synchroniser depth, used to align capture with a driven clock edge
  localparam int unsigned SYNC_LAT         = 2;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    ROLE_IDLE,
    ROLE_ADD_BUS,
    ROLE_PKT_IN,
    ROLE_PORT_ADD,
    ROLE_PORT_DROP
  } role_e;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [APB_AW-1:0] paddr;
    logic [APB_DW-1:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic              pready;
    logic [APB_DW-1:0] prdata;
    logic              pslverr;
  } apb_rsp_s;

  typedef struct packed {
    logic o;
    logic oe_n;
  } pin_drv_s;

  typedef struct packed {
    logic  valid;
    logic  data;
    role_e role;
  } cap_s;

endpackage

// file: design/add_bus_capture.sv
// Purpose: capture of the shared pin on the falling edge of the add bus clock
// Assumes: the add bus clock may stop between frames
// Notes:   a toggle marks each capture; the bit is held until the next one
`timescale 1ns/1ps
module add_bus_capture (
  input  wire logic add_bus_ch2_clock,
  input  wire logic presetn,
  input  wire logic add_bus_ch2_bit3,
  output logic      cap_toggle,
  output logic      cap_bit
);

  typedef struct packed {
    logic toggle;
    logic data;
  } link_s;

  link_s r;
  link_s next_r;

  // ==========================================================
  // capture
  always_comb begin
    next_r        = r;
    next_r.data   = add_bus_ch2_bit3;
    next_r.toggle = ~r.toggle;
  end

  always_ff @(negedge add_bus_ch2_clock or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign cap_toggle = r.toggle;
  assign cap_bit    = r.data;

endmodule

// file: tb/pin_mux_partner.sv
// Purpose: far-side model of the shared pin: system equipment and port circuitry
// Assumes: mode 0 add bus, 1 packet, 2 port add, 3 port drop or idle
// Notes:   its clocks stand still outside their role
`timescale 1ns/1ps
module pin_mux_partner (
  input  wire logic                  byte_clock,
  input  wire logic [1:0]            mode,
  input  wire pin_mux_pkg::pin_drv_s pin_drv,
  output logic                       add_clk,
  output logic                       port_clk,
  output logic                       pin_in,
  output logic                       last_bit
);
  import pin_mux_pkg::*;
  logic [7:0] pat = 8'hB4;
  // odd offset keeps these clocks unrelated in phase to pclk
  initial begin
    add_clk = 1'b0;
    port_clk = 1'b0;
    #7;
    forever begin
      #62.5;
      add_clk = (mode == 2'h0) && !add_clk;
      port_clk = (mode == 2'h2) && !port_clk;
    end
  end
  // data moves half a period away from each sampling edge
  always @(posedge add_clk or negedge byte_clock or negedge port_clk) begin
    pat <= {pat[6:0], pat[7]};
  end
  always @(negedge add_clk or posedge byte_clock or posedge port_clk) begin
    last_bit <= pat[7];
  end
  assign pin_in = pin_drv.oe_n ? pat[7] : pin_drv.o;
endmodule

// file: tb/pin_mux_chk.sv
// Purpose: port checks of the shared pin mux
// Assumes: pclk domain only
// Notes:   add bus capture timing is judged by the bench
`timescale 1ns/1ps
module pin_mux_chk #(
  parameter logic [pin_mux_pkg::DIV_W-1:0] PKT_HALF  = 8'h04,
  parameter logic [pin_mux_pkg::DIV_W-1:0] PORT_HALF = 8'h04
) (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire pin_mux_pkg::apb_req_s apb_req,
  input wire pin_mux_pkg::apb_rsp_s apb_rsp,
  input wire logic                  port_clock_in,
  input wire pin_mux_pkg::pin_drv_s pin_drv,
  input wire pin_mux_pkg::pin_drv_s port_clock_drv,
  input wire logic                  pkt_ctrl_ch2_byte_clock,
  input wire logic                  drop_neg_data,
  input wire logic                  drop_req,
  input wire pin_mux_pkg::cap_s     cap
);
  import pin_mux_pkg::*;
  logic [7:0] dcnt;
  logic       seen;
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  // cycles since the last drop bit; seen skips the first bit of a run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dcnt <= 8'h00;
      seen <= 1'b0;
    end else begin
      dcnt <= drop_req ? 8'h00 : dcnt + 8'h01;
      seen <= !pin_drv.oe_n && (seen || drop_req);
    end
  end
  a_drive_pair: assert property (pin_drv.oe_n == port_clock_drv.oe_n)
    else $error("pin and port clock drivers disagree");
  a_pkt_no_drive: assert property (pkt_ctrl_ch2_byte_clock |-> pin_drv.oe_n)
    else $error("pin driven while byte clock runs");
  a_pkt_rise_sample: assert property (cap.valid && cap.role == ROLE_PKT_IN |->
    $past(pkt_ctrl_ch2_byte_clock, 2) && !$past(pkt_ctrl_ch2_byte_clock, 3))
    else $error("packet bit not taken after byte clock rise");
  a_add_bus_input: assert property (cap.valid && cap.role == ROLE_ADD_BUS |-> pin_drv.oe_n && !pkt_ctrl_ch2_byte_clock)
    else $error("add bus capture with other role active");
  a_port_add_rise: assert property (cap.valid && cap.role == ROLE_PORT_ADD |->
    pin_drv.oe_n && $past(port_clock_in, 3) && !$past(port_clock_in, 4))
    else $error("port add capture not after port clock rise");
  a_drop_update: assert property ($fell(port_clock_drv.o) && !port_clock_drv.oe_n |->
    drop_req && pin_drv.o == $past(drop_neg_data))
    else $error("drop bit not updated at port clock fall");
  a_drop_hold: assert property (!pin_drv.oe_n && !$past(pin_drv.oe_n) && !drop_req |-> $stable(pin_drv.o))
    else $error("drop bit moved between falls");
  a_drop_pulse: assert property (drop_req |-> cap.valid && cap.role == ROLE_PORT_DROP && !pin_drv.oe_n)
    else $error("drop pulse outside drop role");
  a_drop_period: assert property (drop_req && seen |-> dcnt == 8'(2 * PORT_HALF - 1))
    else $error("drop bit spacing wrong");
  a_apb_wait: assert property (apb_req.psel && apb_req.penable && !apb_rsp.pready |=> apb_rsp.pready)
    else $error("apb answer late");
  a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready longer than one cycle");
  c_add: cover property (cap.valid && cap.role == ROLE_ADD_BUS);
  c_pkt: cover property (cap.valid && cap.role == ROLE_PKT_IN);
  c_drop: cover property (drop_req && seen);
  c_port_add: cover property (cap.valid && cap.role == ROLE_PORT_ADD);
endmodule
bind ch2_shared_data_bit3_pin_mux pin_mux_chk #(.PKT_HALF(PKT_HALF), .PORT_HALF(PORT_HALF)) u_chk (
  .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp), .port_clock_in(port_clock_in),
  .pin_drv(pin_drv), .port_clock_drv(port_clock_drv), .pkt_ctrl_ch2_byte_clock(pkt_ctrl_ch2_byte_clock),
  .drop_neg_data(drop_neg_data), .drop_req(drop_req), .cap(cap)
);

// file: tb/ch2_shared_data_bit3_pin_mux_tb.sv
// Purpose: self-checking bench of the shared pin mux
// Assumes: default divider halves
// Notes:   one pass per role, eight captures each except idle, which has none
`timescale 1ns/1ps
module ch2_shared_data_bit3_pin_mux_tb;
  import pin_mux_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        drop_neg_data = 1'b0;
  logic [1:0]  mode = 2'h3;
  logic        exp_drop = 1'b0;
  logic        add_clk, port_clk, byte_clk, drop_req, pin_in, port_clock_in, last_bit, err;
  logic [31:0] rd;
  apb_req_s    req = '0;
  apb_rsp_s    rsp;
  pin_drv_s    pin_drv, port_clock_drv;
  cap_s        cap;
  int          failures = 0;
  int          compares = 0;
  // add enable beats a mapper drop setting in the first entry
  logic [31:0] ctrl_tab [5] = '{32'h0000000B, 32'h00000000, 32'h00000002, 32'h0000000A, 32'h00000004};
  role_e       role_tab [5] = '{ROLE_ADD_BUS, ROLE_PKT_IN, ROLE_PORT_ADD, ROLE_PORT_DROP, ROLE_IDLE};
  assign port_clock_in = port_clock_drv.oe_n ? port_clk : port_clock_drv.o;
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    drop_neg_data <= ~drop_neg_data;
  end
  ch2_shared_data_bit3_pin_mux DUT (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .add_bus_ch2_clock(add_clk), .pin_in(pin_in), .pin_drv(pin_drv), .port_clock_in(port_clock_in),
    .port_clock_drv(port_clock_drv), .pkt_ctrl_ch2_byte_clock(byte_clk), .drop_neg_data(drop_neg_data),
    .drop_req(drop_req), .cap(cap));
  pin_mux_partner u_far (.byte_clock(byte_clk), .mode(mode), .pin_drv(pin_drv), .add_clk(add_clk),
    .port_clk(port_clk), .pin_in(pin_in), .last_bit(last_bit));
  // ====================
  // tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic timed_out;
    failures++;
    $display("mismatch at %0t: wait timed out", $time);
    give_verdict();
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) timed_out();
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask
  task automatic wait_cap;
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (cap.valid !== 1'b1 && n < 200);
    if (n >= 200) timed_out();
  endtask
  // ====================
  // sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CTRL_OFS, '0);
    check(rd, 32'h00000006);
    apb(1'b0, 12'h010, '0);
    check({rd[30:0], err}, 32'h00000001);
    for (int i = 0; i < 5; i++) begin
      mode <= (i < 3) ? 2'(i) : 2'h3;
      apb(1'b1, CTRL_OFS, ctrl_tab[i]);
      apb(1'b0, STATUS_OFS, '0);
      check(32'(rd[2:0]), 32'(role_tab[i]));
      repeat (12) @(posedge pclk);
      for (int k = 0; k < 8 && i < 4; k++) begin
        wait_cap();
        check(32'(cap.role), 32'(role_tab[i]));
        check(32'(cap.data), 32'(i == 3 ? !drop_neg_data : last_bit));
        check(32'(pin_drv.oe_n), 32'(i != 3));
        if (i == 3) exp_drop = !drop_neg_data;
      end
    end
    // drop bits fall eight cycles apart, so all take one phase of the toggling data
    apb(1'b0, HIST_OFS, '0);
    check(32'(rd[23:16]), {24'h000000, {8{exp_drop}}});
    apb(1'b0, COUNT_OFS, '0);
    check(32'(rd[15:0] >= 16'h0020), 32'h00000001);
    apb(1'b1, COUNT_OFS, '0);
    apb(1'b0, COUNT_OFS, '0);
    check(rd, 32'h00000000);
    check(32'({pin_drv.oe_n, byte_clk}), 32'h00000002);
    give_verdict();
  end
endmodule
